// >>> inc/sbrc_pkg.sv
/*
  Shared constants and carrier types for the regulator, measurement-select
  and pin-function control registers of the system basis chip.
  Assumes the serial command decoder outside hands over one register access
  at a time, already framed into address, write flag and 8-bit data.
*/
package sbrc_pkg;

  // Register addresses as carried in the 5-bit address field of a command
  localparam logic [4:0] SBRC_ADDR_MEASURE = 5'h00;
  localparam logic [4:0] SBRC_ADDR_PINCFG = 5'h11;
  localparam logic [4:0] SBRC_ADDR_REGCTL = 5'h0f;

  // Reset values
  localparam logic [7:0] SBRC_MEASURE_RST = 8'h00;
  localparam logic [7:0] SBRC_PINCFG_RST = 8'h00;
  localparam logic [7:0] SBRC_REGCTL_RST = 8'h00;
  localparam logic [1:0] SBRC_XCVR_DEBUG_RST = 2'h1;

  // Regulator control field positions
  localparam int SBRC_AUX_LSB = 6;
  localparam int SBRC_XCVR_LSB = 3;
  localparam int SBRC_BAL_FORCE_BIT = 2;
  localparam int SBRC_BAL_AUTO_BIT = 1;
  localparam int SBRC_OFF_PERMIT_BIT = 0;

  // Measurement select field positions
  localparam int SBRC_SEL_LSB = 5;
  localparam int SBRC_RES_BIT = 4;
  localparam int SBRC_ATT_BIT = 3;
  localparam logic [7:0] SBRC_MEASURE_MASK = 8'hf8;

  // Regulator field codes
  localparam logic [1:0] SBRC_REG_OFF = 2'h0;
  localparam logic [1:0] SBRC_REG_QUIET = 2'h1;
  localparam logic [1:0] SBRC_REG_FAST = 2'h3;

  // Pin field codes
  localparam logic [1:0] SBRC_PIN_OFF = 2'h0;
  localparam logic [1:0] SBRC_PIN_WAKE = 2'h1;
  localparam logic [1:0] SBRC_PIN_LOW = 2'h2;
  localparam logic [1:0] SBRC_PIN_HIGH = 2'h3;

  // Measurement sources
  localparam logic [2:0] SBRC_SEL_IO0 = 3'h4;
  localparam logic [2:0] SBRC_SEL_IO1 = 3'h5;

  // Blanking times
  localparam int SBRC_CLK_HZ = 25000000;
  localparam int SBRC_BLANK_LONG_US = 1000;
  localparam int SBRC_BLANK_SHORT_US = 25;
  localparam int SBRC_BLANK_LONG_CYC = (SBRC_BLANK_LONG_US * (SBRC_CLK_HZ / 1000000));
  localparam int SBRC_BLANK_SHORT_CYC = (SBRC_BLANK_SHORT_US * (SBRC_CLK_HZ / 1000000));
  localparam int SBRC_CNT_W = 16;

  typedef enum logic [1:0] {
    SBRC_MODE_NORMAL = 2'h0,
    SBRC_MODE_DEBUG = 2'h1,
    SBRC_MODE_LOWPWR = 2'h3,
    SBRC_MODE_OTHER = 2'h2
  } sbrc_mode_t;

  typedef enum logic [1:0] {
    SBRC_FLT_IDLE = 2'h0,
    SBRC_FLT_BLANK = 2'h1,
    SBRC_FLT_TRIP = 2'h3
  } sbrc_flt_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
    logic [7:0] data;
  } sbrc_req_t;

  typedef struct packed {
    logic on;
    logic report_flags;
    logic thermal_prot;
    logic tripped;
  } sbrc_reg_ctl_t;

  typedef struct packed {
    logic drive_high;
    logic drive_low;
    logic wake_enable;
    logic protect;
  } sbrc_pin_ctl_t;

  typedef struct packed {
    logic [2:0] source;
    logic internal_sense_resistor_enable;
    logic attenuate;
    logic gain;
  } sbrc_meas_t;

endpackage

// >>> src/sbrc_ctrl.sv
/*
  Regulator control, measurement select and pin function registers, with
  the control outputs decoded from them.
  Assumes a serial frame decoder outside delivers one access per cycle and
  takes the read data in the cycle after the request.
*/
`timescale 1ns/1ps

module sbrc_ctrl
  import sbrc_pkg::*;
#(
  parameter int BLANK_LONG_CYC = SBRC_BLANK_LONG_CYC,
  parameter int NUM_PINS = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire sbrc_req_t req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire sbrc_mode_t dev_mode,
  input wire logic aux_fault,
  input wire logic xcvr_fault,
  input wire logic vdd_current_high,
  input wire logic supply_off_request,
  input wire logic bus_termination_one,
  input wire logic bus_termination_two,
  input wire logic bus_term_one_drive,
  input wire logic bus_term_two_drive,
  output sbrc_reg_ctl_t aux_ctl,
  output sbrc_reg_ctl_t transceiver_supply_regulator,
  output logic aux_blank_short,
  output logic xcvr_blank_short,
  output logic ballast_enable,
  output logic supply_off_enter,
  output sbrc_meas_t measurement_output_pin,
  output sbrc_pin_ctl_t [NUM_PINS-1:0] pin_ctl
);

  initial
  begin
    if (NUM_PINS != 4)
      $error("sbrc_ctrl: exactly four pin fields are supported");
    if (BLANK_LONG_CYC < 1)
      $error("sbrc_ctrl: blanking count must be positive");
  end

  typedef struct packed {
    logic [7:0] regctl;
    logic [7:0] measure;
    logic [7:0] pincfg;
    logic [7:0] rd_data;
    logic rd_valid;
    logic debug_seen;
    sbrc_reg_ctl_t aux;
    sbrc_reg_ctl_t xcvr;
    logic ballast;
    logic off_enter;
    sbrc_meas_t meas;
    sbrc_pin_ctl_t [3:0] pins;
  } st_t;

  st_t s_q;
  st_t s_d;
  logic aux_trip;
  logic xcvr_trip;

  // Shared decode for regulator fields
  function automatic sbrc_reg_ctl_t reg_decode(input logic [1:0] f, input logic trip,
                                               input logic thermal);
    sbrc_reg_ctl_t r;
    r.on = (f != SBRC_REG_OFF) && !trip;
    r.report_flags = (f != SBRC_REG_OFF) && (f != SBRC_REG_QUIET);
    r.thermal_prot = thermal && (f != SBRC_REG_OFF);
    r.tripped = trip;
    return r;
  endfunction

  // Shared decode for pin fields; low-side exists only on the lower two pins
  function automatic sbrc_pin_ctl_t pin_decode(input logic [1:0] f, input logic low_ok,
                                               input logic lowpwr);
    sbrc_pin_ctl_t p;
    p.wake_enable = (f == SBRC_PIN_WAKE);
    p.drive_low = low_ok && (f == SBRC_PIN_LOW);
    p.drive_high = (f == SBRC_PIN_HIGH) || (!low_ok && f == SBRC_PIN_LOW);
    p.protect = (p.drive_low || p.drive_high) && !lowpwr;
    return p;
  endfunction

  sbrc_fault_blank #(
    .LONG_CYC(BLANK_LONG_CYC),
    .SHORT_CYC(SBRC_BLANK_SHORT_CYC)
  ) u_aux_blank (
    .clk(clk),
    .rst_n(rst_n),
    .mode(s_q.regctl[SBRC_AUX_LSB +: 2]),
    .fault(aux_fault && s_q.aux.on),
    .tripped(aux_trip)
  );

  sbrc_fault_blank #(
    .LONG_CYC(BLANK_LONG_CYC),
    .SHORT_CYC(SBRC_BLANK_SHORT_CYC)
  ) u_xcvr_blank (
    .clk(clk),
    .rst_n(rst_n),
    .mode(s_q.regctl[SBRC_XCVR_LSB +: 2]),
    .fault(xcvr_fault && s_q.xcvr.on),
    .tripped(xcvr_trip)
  );

  always_comb
  begin
    logic xcvr_off;
    logic [1:0] pf;
    xcvr_off = 1'b0;
    pf = 2'h0;
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    xcvr_off = (s_q.regctl[SBRC_XCVR_LSB +: 2] == SBRC_REG_OFF);

    // Entering debug mode loads the quiet transceiver setting once
    s_d.debug_seen = (dev_mode == SBRC_MODE_DEBUG);
    if (dev_mode == SBRC_MODE_DEBUG && !s_q.debug_seen)
      s_d.regctl[SBRC_XCVR_LSB +: 2] = SBRC_XCVR_DEBUG_RST;

    if (req.valid)
    begin
      s_d.rd_valid = 1'b1;
      s_d.rd_data = 8'h00;
      case (req.addr)
        SBRC_ADDR_REGCTL:
        begin
          if (req.write)
            s_d.regctl = req.data;
          s_d.rd_data = s_q.regctl;
        end
        SBRC_ADDR_MEASURE:
        begin
          // Access is dropped and reads zero while the supply is off
          if (!xcvr_off)
          begin
            if (req.write && dev_mode == SBRC_MODE_NORMAL)
              s_d.measure = req.data & SBRC_MEASURE_MASK;
            s_d.rd_data = s_q.measure & SBRC_MEASURE_MASK;
          end
        end
        SBRC_ADDR_PINCFG:
        begin
          if (req.write)
            s_d.pincfg = req.data;
          s_d.rd_data = s_q.pincfg;
        end
        default:
          s_d.rd_data = 8'h00;
      endcase
    end

    if (xcvr_off || dev_mode != SBRC_MODE_NORMAL)
      s_d.measure = SBRC_MEASURE_RST;
    if (s_d.regctl[SBRC_XCVR_LSB +: 2] == SBRC_REG_OFF)
      s_d.measure = SBRC_MEASURE_RST;

    s_d.aux = reg_decode(s_d.regctl[SBRC_AUX_LSB +: 2], aux_trip, 1'b0);
    s_d.xcvr = reg_decode(s_d.regctl[SBRC_XCVR_LSB +: 2], xcvr_trip, 1'b1);

    s_d.ballast = s_d.regctl[SBRC_BAL_FORCE_BIT]
                  || (s_d.regctl[SBRC_BAL_AUTO_BIT] && vdd_current_high);
    s_d.off_enter = supply_off_request && s_d.regctl[SBRC_OFF_PERMIT_BIT];

    s_d.meas.source = s_d.measure[SBRC_SEL_LSB +: 3];
    s_d.meas.internal_sense_resistor_enable = s_d.measure[SBRC_RES_BIT];
    s_d.meas.attenuate = 1'b0;
    s_d.meas.gain = 1'b0;
    if (s_d.meas.source == SBRC_SEL_IO0 || s_d.meas.source == SBRC_SEL_IO1)
    begin
      s_d.meas.attenuate = s_d.measure[SBRC_ATT_BIT];
      s_d.meas.gain = !s_d.measure[SBRC_ATT_BIT];
    end

    for (int i = 0; i < 4; i++)
    begin
      pf = s_d.pincfg[2*i +: 2];
      s_d.pins[i] = pin_decode(pf, (i < 2), dev_mode == SBRC_MODE_LOWPWR);
    end
    // Bits 1:0 and 3:2 drive the lower pins, both sides available
    s_d.pins[0].protect = s_d.pins[0].protect;
    s_d.pins[1].protect = s_d.pins[1].protect;

    // Bus terminations take the upper pins away from the field setting
    if (bus_termination_one)
    begin
      s_d.pins[2] = '0;
      s_d.pins[2].drive_high = bus_term_one_drive;
      s_d.pins[2].protect = bus_term_one_drive;
    end
    else
      s_d.pins[2] = pin_decode(s_d.pincfg[5:4], 1'b0, 1'b0);
    if (bus_termination_two)
    begin
      s_d.pins[3] = '0;
      s_d.pins[3].drive_high = bus_term_two_drive;
      s_d.pins[3].protect = bus_term_two_drive;
    end
    else
      s_d.pins[3] = pin_decode(s_d.pincfg[7:6], 1'b0, 1'b0);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.regctl <= SBRC_REGCTL_RST;
      s_q.measure <= SBRC_MEASURE_RST;
      s_q.pincfg <= SBRC_PINCFG_RST;
    end
    else
      s_q <= s_d;
  end

  assign rd_data = s_q.rd_data;
  assign rd_valid = s_q.rd_valid;
  assign aux_ctl = s_q.aux;
  assign transceiver_supply_regulator = s_q.xcvr;
  assign aux_blank_short = (s_q.regctl[SBRC_AUX_LSB +: 2] == SBRC_REG_FAST);
  assign xcvr_blank_short = (s_q.regctl[SBRC_XCVR_LSB +: 2] == SBRC_REG_FAST);
  assign ballast_enable = s_q.ballast;
  assign supply_off_enter = s_q.off_enter;
  assign measurement_output_pin = s_q.meas;
  assign pin_ctl = s_q.pins;

endmodule

// >>> src/sbrc_fault_blank.sv
/*
  One regulator's fault blanking timer: a fault that persists through the
  selected blanking time trips the regulator off.
  Assumes the fault input is already synchronous to clk.
*/
`timescale 1ns/1ps
module sbrc_fault_blank
  import sbrc_pkg::*;
#(
  parameter int LONG_CYC = SBRC_BLANK_LONG_CYC,
  parameter int SHORT_CYC = SBRC_BLANK_SHORT_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  input wire logic fault,
  output logic tripped
);

  initial
  begin
    if (LONG_CYC < 1 || SHORT_CYC < 1 || LONG_CYC >= (1 << SBRC_CNT_W))
      $error("sbrc_fault_blank: blanking count out of range");
  end

  typedef struct packed {
    sbrc_flt_t st;
    logic [SBRC_CNT_W-1:0] cnt;
  } fb_state_t;

  fb_state_t s_q;
  fb_state_t s_d;
  logic [SBRC_CNT_W-1:0] limit;

  always_comb
  begin
    limit = (mode == SBRC_REG_FAST) ? SBRC_CNT_W'(SHORT_CYC - 1) : SBRC_CNT_W'(LONG_CYC - 1);
    s_d = s_q;
    case (s_q.st)
      SBRC_FLT_IDLE:
      begin
        s_d.cnt = '0;
        if (fault && mode != SBRC_REG_OFF)
          s_d.st = SBRC_FLT_BLANK;
      end
      SBRC_FLT_BLANK:
      begin
        // Short glitches under the blanking time do not shut down
        if (!fault || mode == SBRC_REG_OFF)
          s_d.st = SBRC_FLT_IDLE;
        else if (s_q.cnt >= limit)
          s_d.st = SBRC_FLT_TRIP;
        else
          s_d.cnt = s_q.cnt + 1'b1;
      end
      SBRC_FLT_TRIP:
      begin
        // Stays off until software turns the regulator off and on again
        if (mode == SBRC_REG_OFF)
          s_d.st = SBRC_FLT_IDLE;
      end
      default:
        s_d.st = SBRC_FLT_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_q <= '{st: SBRC_FLT_IDLE, cnt: '0};
    else
      s_q <= s_d;
  end

  assign tripped = (s_q.st == SBRC_FLT_TRIP);

endmodule

// >>> test/sbrc_ctrl_assertions.sv
/*
  Port checker for the control register block.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module sbrc_ctrl_assertions
  import sbrc_pkg::*;
#(
  parameter int BLANK_LONG_CYC = SBRC_BLANK_LONG_CYC,
  parameter int NUM_PINS = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire sbrc_req_t req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire sbrc_mode_t dev_mode,
  input wire logic aux_fault,
  input wire logic supply_off_request,
  input wire sbrc_reg_ctl_t aux_ctl,
  input wire sbrc_reg_ctl_t transceiver_supply_regulator,
  input wire logic supply_off_enter,
  input wire sbrc_meas_t measurement_output_pin,
  input wire sbrc_pin_ctl_t [NUM_PINS-1:0] pin_ctl
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Short blanking is fixed, so it may outlast a scaled-down long one
  localparam int TRIP_MAX = (BLANK_LONG_CYC > SBRC_BLANK_SHORT_CYC ?
                             BLANK_LONG_CYC : SBRC_BLANK_SHORT_CYC) + 4;
  logic [15:0] flt_cnt_q;
  logic [15:0] flt_cnt_d;
  always_comb flt_cnt_d = (aux_fault && aux_ctl.on) ? flt_cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge clk) flt_cnt_q <= rst_n ? flt_cnt_d : 16'h0000;
  sequence s_access(a);
    req.valid && req.addr == a;
  endsequence
  sequence s_lowpwr_held;
    (dev_mode == SBRC_MODE_LOWPWR) [*2];
  endsequence
  answer_pulse_a: assert property (req.valid |=> rd_valid)
    else $error("no answer one cycle after access");
  measure_low_zero_a: assert property (s_access(SBRC_ADDR_MEASURE) |=> rd_data[2:0] == 3'h0)
    else $error("measure low bits not zero");
  measure_blocked_a: assert property (s_access(SBRC_ADDR_MEASURE) ##0
    (!transceiver_supply_regulator.on && !transceiver_supply_regulator.tripped) |=> rd_data == 8'h00)
    else $error("measure read while supply off");
  measure_cleared_a: assert property (dev_mode != SBRC_MODE_NORMAL |=>
    measurement_output_pin == '0)
    else $error("measure select kept outside normal mode");
  off_needs_request_a: assert property (!supply_off_request |=> !supply_off_enter)
    else $error("supply off entered without request");
  trip_bound_a: assert property (flt_cnt_q <= TRIP_MAX)
    else $error("aux regulator kept on past blanking");
  tripped_off_a: assert property (aux_ctl.tripped |-> !aux_ctl.on)
    else $error("tripped aux regulator still on");
  xcvr_thermal_a: assert property (transceiver_supply_regulator.on |->
    transceiver_supply_regulator.thermal_prot)
    else $error("transceiver supply on without thermal protection");
  lowpwr_unprot_a: assert property (s_lowpwr_held ##0
    (pin_ctl[0].drive_high || pin_ctl[0].drive_low) |-> !pin_ctl[0].protect)
    else $error("pin 0 protected in low power");
endmodule
bind sbrc_ctrl sbrc_ctrl_assertions #(
  .BLANK_LONG_CYC(BLANK_LONG_CYC),
  .NUM_PINS(NUM_PINS)
) u_assertions (
  .clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
  .dev_mode(dev_mode), .aux_fault(aux_fault), .supply_off_request(supply_off_request),
  .aux_ctl(aux_ctl), .transceiver_supply_regulator(transceiver_supply_regulator),
  .supply_off_enter(supply_off_enter), .measurement_output_pin(measurement_output_pin),
  .pin_ctl(pin_ctl)
);

// >>> test/sbrc_host_model.sv
/*
  Host side model: issues one register access at a time on req.
  Assumes the bench calls xfer from a single process.
*/
`timescale 1ns/1ps
module sbrc_host_model
  import sbrc_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output sbrc_req_t req
);
  initial req = '0;
  // Valid drops and data goes inverted once released, so a stale bus never reads as valid
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
                      output logic [7:0] q);
  begin
    @(posedge clk);
    req <= '{1'b1, w, a, d};
    @(posedge clk);
    req <= '{1'b0, 1'b0, a, ~d};
    #1;
    q = rd_valid ? rd_data : 8'hxx;
  end
  endtask
endmodule

// >>> test/testbench.sv
/*
  Self-checking bench for the control registers.
  Assumes the host model drives req; the bench drives all other inputs.
*/
`timescale 1ns/1ps
module testbench;
  import sbrc_pkg::*;
  localparam int LONG = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sbrc_mode_t dev_mode = SBRC_MODE_NORMAL;
  logic aux_fault = 1'b0;
  logic xcvr_fault = 1'b0;
  logic cur_high = 1'b0;
  logic off_req = 1'b0;
  logic term_one = 1'b0;
  logic term_two = 1'b0;
  logic term_one_drv = 1'b0;
  logic term_two_drv = 1'b0;
  sbrc_req_t req;
  logic [7:0] rd_data;
  logic [7:0] q;
  logic rd_valid, aux_bs, xcvr_bs, ballast, off_enter;
  sbrc_reg_ctl_t aux_ctl, xcvr;
  sbrc_meas_t meas;
  sbrc_pin_ctl_t [3:0] pins;
  int miscompares = 0;
  int total_checks = 0;
  initial
  begin
    forever #20 clk = ~clk;
  end
  sbrc_host_model host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));
  sbrc_ctrl #(.BLANK_LONG_CYC(LONG)) dut (
    .clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .dev_mode(dev_mode), .aux_fault(aux_fault), .xcvr_fault(xcvr_fault),
    .vdd_current_high(cur_high), .supply_off_request(off_req),
    .bus_termination_one(term_one), .bus_termination_two(term_two),
    .bus_term_one_drive(term_one_drv), .bus_term_two_drive(term_two_drv),
    .aux_ctl(aux_ctl), .transceiver_supply_regulator(xcvr), .aux_blank_short(aux_bs),
    .xcvr_blank_short(xcvr_bs), .ballast_enable(ballast), .supply_off_enter(off_enter),
    .measurement_output_pin(meas), .pin_ctl(pins)
  );
  task automatic finish_test;
  begin
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic tick(input int n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
  begin
    host.xfer(1'b1, a, d, q);
  end
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
  begin
    host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  end
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(SBRC_ADDR_REGCTL, SBRC_REGCTL_RST);
    rd(SBRC_ADDR_MEASURE, SBRC_MEASURE_RST);
    rd(SBRC_ADDR_PINCFG, SBRC_PINCFG_RST);
    rd(5'h05, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(SBRC_ADDR_REGCTL, {c[1:0], 1'b0, c[1:0], 3'h0});
      rd(SBRC_ADDR_REGCTL, {c[1:0], 1'b0, c[1:0], 3'h0});
      chk({aux_ctl.on, aux_ctl.report_flags}, {c != 0, c[1]});
      chk(aux_bs, c == 3);
      chk({xcvr.on, xcvr.report_flags, xcvr.thermal_prot, xcvr_bs},
          {c != 0, c[1], c != 0, c == 3});
    end
    wr(SBRC_ADDR_REGCTL, 8'h04);
    tick(1);
    chk(ballast, 1'b1);
    wr(SBRC_ADDR_REGCTL, 8'h02);
    tick(1);
    chk(ballast, 1'b0);
    @(posedge clk);
    cur_high <= 1'b1;
    off_req <= 1'b1;
    tick(2);
    chk({ballast, off_enter}, 2'b10);
    wr(SBRC_ADDR_REGCTL, 8'h01);
    tick(1);
    chk({ballast, off_enter}, 2'b01);
    @(posedge clk);
    off_req <= 1'b0;
    wr(SBRC_ADDR_MEASURE, 8'hff);
    rd(SBRC_ADDR_MEASURE, 8'h00);
    wr(SBRC_ADDR_REGCTL, 8'h10);
    wr(SBRC_ADDR_MEASURE, 8'hff);
    rd(SBRC_ADDR_MEASURE, 8'hf8);
    chk({meas.source, meas.internal_sense_resistor_enable}, 4'hf);
    for (int s = 0; s < 8; s++)
    begin
      wr(SBRC_ADDR_MEASURE, {s[2:0], 5'h08});
      chk(meas, {s[2:0], 1'b0, s == 4 || s == 5, 1'b0});
    end
    wr(SBRC_ADDR_MEASURE, 8'h80);
    chk(meas, {3'h4, 3'h1});
    @(posedge clk);
    dev_mode <= SBRC_MODE_OTHER;
    tick(2);
    chk(meas, 8'h00);
    @(posedge clk);
    dev_mode <= SBRC_MODE_DEBUG;
    tick(2);
    rd(SBRC_ADDR_REGCTL, {3'h0, SBRC_XCVR_DEBUG_RST, 3'h0});
    chk({xcvr.on, xcvr.report_flags}, 2'b10);
    @(posedge clk);
    dev_mode <= SBRC_MODE_NORMAL;
    rd(SBRC_ADDR_MEASURE, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(SBRC_ADDR_PINCFG, {4{c[1:0]}});
      rd(SBRC_ADDR_PINCFG, {4{c[1:0]}});
      for (int p = 0; p < 4; p++)
        chk({pins[p].drive_high, pins[p].drive_low, pins[p].wake_enable},
            {c == 3 || (c == 2 && p > 1), c == 2 && p < 2, c == 1});
    end
    @(posedge clk);
    dev_mode <= SBRC_MODE_LOWPWR;
    tick(2);
    chk({pins[0].protect, pins[1].protect, pins[3].protect}, 3'b001);
    @(posedge clk);
    dev_mode <= SBRC_MODE_NORMAL;
    term_one <= 1'b1;
    term_one_drv <= 1'b1;
    term_two <= 1'b1;
    tick(2);
    chk({pins[2].drive_high, pins[2].drive_low, pins[2].wake_enable,
         pins[3].drive_high, pins[3].wake_enable}, 5'b10000);
    @(posedge clk);
    term_one <= 1'b0;
    term_one_drv <= 1'b0;
    term_two <= 1'b0;
    wr(SBRC_ADDR_REGCTL, 8'h18);
    @(posedge clk);
    xcvr_fault <= 1'b1;
    tick(600);
    chk({xcvr.on, xcvr.tripped}, 2'b10);
    tick(40);
    chk({xcvr.on, xcvr.tripped}, 2'b01);
    @(posedge clk);
    xcvr_fault <= 1'b0;
    @(posedge clk);
    dev_mode <= SBRC_MODE_NORMAL;
    wr(SBRC_ADDR_REGCTL, 8'h80);
    @(posedge clk);
    aux_fault <= 1'b1;
    tick(LONG - 5);
    chk({aux_ctl.on, aux_ctl.tripped}, 2'b10);
    tick(12);
    chk({aux_ctl.on, aux_ctl.tripped}, 2'b01);
    @(posedge clk);
    aux_fault <= 1'b0;
    wr(SBRC_ADDR_REGCTL, 8'h00);
    wr(SBRC_ADDR_REGCTL, 8'h80);
    chk(aux_ctl.on, 1'b1);
    finish_test();
  end
endmodule
